//--- hw/tcac_defines.vh
// constants for the tdm context assembly control block
// Functional notes
// - Up to 128 contexts; each table entry names context 0 to 127.
// - Every incoming timeslot reads the lookup table to find its context.
// - member_on set includes the slot in the payload; clear excludes it.
// - member_next stages membership: joins or leaves at the next update.
// - One lead_slot per context marks the first channel after frame start.
// - lead_next makes the slot first channel after the next update.
// - Per context: cache pointer, payload length, update and teardown bits.
// - Update waits for first channel, copies staged bits, caches its data.
// - Further members copied and cached; update bit clears back at first slot.
// - Running context: update starts only after the current packet completes.
// - Remaining slots carry on undisturbed; staged changes apply after update.
// - First packet after an update inverts the descriptor switch bit.
// - Teardown sends the open packet as the final one only if it holds bytes, and clears the context's table flags.
// - Payload 1 to 1500 bytes, always whole TDM frames.
// - Channels placed in scan order from the first channel.
// - Cache space per context; full packets handed to the memory manager.
`ifndef TCAC_DEFINES_VH
`define TCAC_DEFINES_VH

// register port word addresses
`define TCAC_AW          11
`define TCAC_LUT_BASE    11'h000
`define TCAC_CTRL_BASE   11'h400
`define TCAC_PTR_BASE    11'h480
`define TCAC_STAT_ADDR   11'h500

// lookup table entry layout
`define TCAC_LUT_W       11
`define TCAC_CID_MSB     6
`define TCAC_ON_BIT      7
`define TCAC_NEXT_BIT    8
`define TCAC_LEAD_BIT    9
`define TCAC_LNEXT_BIT   10

// context control word layout
`define TCAC_LEN_MSB     10
`define TCAC_UPD_BIT     16
`define TCAC_TDN_BIT     17
`define TCAC_SW_BIT      18
`define TCAC_RUN_BIT     19

// status word layout
`define TCAC_ST_OVF_BIT  0
`define TCAC_ST_UPD_BIT  1
`define TCAC_ST_CLR_BIT  2
`define TCAC_ST_REQ_BIT  3

// reset and limit values
`define TCAC_LEN_RST     11'h020
`define TCAC_LEN_MAX     11'h5DC
`define TCAC_PTR_RST     12'h000

`endif

//--- hw/tcac_dpram.v
// two-port memory: port a registered read, port b asynchronous read
`timescale 1ns/10ps
module tcac_dpram #(
  parameter DW = 8,
  parameter AW = 10
) (
  input  wire          clk,     // system clock
  input  wire          a_we,    // port a write enable
  input  wire [AW-1:0] a_addr,  // port a address
  input  wire [DW-1:0] a_wdata, // port a write data
  output reg  [DW-1:0] a_rdata, // port a read data, one cycle later
  input  wire          b_we,    // port b write enable
  input  wire [AW-1:0] b_addr,  // port b address
  input  wire [DW-1:0] b_wdata, // port b write data
  output wire [DW-1:0] b_rdata  // port b read data, same cycle
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // port a is written last so it wins a same-address collision
  always @(posedge clk) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    a_rdata <= mem[a_addr];
  end

  assign b_rdata = mem[b_addr];

endmodule

//--- hw/tcac_req.v
// single-entry packet hand-over request to the memory manager
`timescale 1ns/10ps
module tcac_req (
  input  wire        clk,      // system clock
  input  wire        rst,      // async reset, active high
  input  wire        load,     // packet closed this cycle
  input  wire [6:0]  in_ctx,   // context of the closed packet
  input  wire [11:0] in_base,  // cache base of the packet
  input  wire [10:0] in_len,   // payload bytes
  input  wire        in_sw,    // context switch bit
  input  wire        in_last,  // final packet of a teardown
  input  wire        gnt,      // memory manager takes the request
  output reg         req,      // request pending
  output reg  [6:0]  ctx,      // held context
  output reg  [11:0] base,     // held cache base
  output reg  [10:0] len,      // held payload length
  output reg         sw,       // held switch bit
  output reg         last,     // held final packet flag
  output wire        drop      // load refused, request still pending
);

  // a new packet is refused while the previous one is not yet granted
  assign drop = load & req & ~gnt;

  // hold descriptor until granted; a grant frees the slot for a new load
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      req  <= 1'b0;
      ctx  <= 7'h00;
      base <= 12'h000;
      len  <= 11'h000;
      sw   <= 1'b0;
      last <= 1'b0;
    end else if (load && (!req || gnt)) begin
      req  <= 1'b1;
      ctx  <= in_ctx;
      base <= in_base;
      len  <= in_len;
      sw   <= in_sw;
      last <= in_last;
    end else if (gnt) begin
      req  <= 1'b0;
    end
  end

endmodule

//--- hw/tcac_ctx_ctrl.v
// context lookup, payload assembly and update/teardown control
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "tcac_defines.vh"
module tcac_ctx_ctrl #(
  parameter NCTX  = 128,
  parameter SLOTW = 10,
  parameter CAW   = 12
) (
  input  wire                clk,         // system clock, 25 MHz
  input  wire                rst,         // async reset, active high
  input  wire                ts_valid,    // new timeslot byte, one cycle
  input  wire [SLOTW-1:0]    ts_index,    // stream and timeslot position
  input  wire [7:0]          ts_data,     // timeslot byte
  input  wire [`TCAC_AW-1:0] reg_addr,    // register word address
  input  wire [31:0]         reg_wdata,   // register write data
  input  wire                reg_we,      // register write strobe
  input  wire                reg_re,      // register read strobe
  output reg  [31:0]         reg_rdata,   // read data, cycle after reg_re
  output wire                mem_req,     // packet ready for transfer
  output wire [6:0]          mem_ctx,     // context of that packet
  output wire [CAW-1:0]      mem_base,    // cache base of that packet
  output wire [10:0]         mem_len,     // payload length in bytes
  output wire                mem_switch,  // context switch bit
  output wire                mem_last,    // final packet of a teardown
  input  wire                mem_gnt,     // manager accepts the packet
  input  wire [CAW-1:0]      mem_rd_addr, // cache read address
  output reg  [7:0]          mem_rd_data  // cache byte, one cycle later
);

  localparam ST_IDLE = 3'b001;
  localparam ST_UPD  = 3'b010;
  localparam ST_CLR  = 3'b100;

  // per-context memory
  reg [10:0]      ctx_len [0:NCTX-1];
  reg [CAW-1:0]   ctx_ptr [0:NCTX-1];
  reg [10:0]      ctx_cnt [0:NCTX-1];
  reg [NCTX-1:0]  ctx_upd;
  reg [NCTX-1:0]  ctx_tdn;
  reg [NCTX-1:0]  ctx_sw;
  reg [NCTX-1:0]  ctx_run;
  reg [NCTX-1:0]  ctx_bank;

  reg [2:0]             state;
  reg [6:0]             eng_ctx;
  reg [SLOTW-1:0]       eng_slot;
  reg                   s1_valid;
  reg [SLOTW-1:0]       s1_idx;
  reg [7:0]             s1_data;
  reg                   ovf;
  integer               i;

  wire [`TCAC_LUT_W-1:0] lut_q;
  wire [`TCAC_LUT_W-1:0] lut_b_q;
  wire [7:0]             cache_b_q;
  wire                   drop;

  // decode of the looked-up entry
  reg [6:0]             e_cid;
  reg                   e_on, e_nx, e_ld, e_lnx;
  reg [10:0]            c_cnt, c_len;
  reg                   c_run, full, back;
  reg                   start_upd, start_tdn, upd_mode, clr_mode;
  reg                   eff_on, eff_ld, pkt_close, store;
  reg [10:0]            wr_off, next_cnt;
  reg [`TCAC_LUT_W-1:0] next_lut;
  reg                   lut_we;
  reg [CAW-1:0]         cache_addr;
  reg [CAW-1:0]         pkt_base;
  reg                   wr_bank;

  // register port decode
  wire sw_lut  = reg_addr < `TCAC_CTRL_BASE;
  wire sw_ctrl = (reg_addr >= `TCAC_CTRL_BASE) &&
                 (reg_addr < `TCAC_PTR_BASE);
  wire sw_ptr  = (reg_addr >= `TCAC_PTR_BASE) &&
                 (reg_addr < `TCAC_STAT_ADDR);
  wire sw_stat = reg_addr == `TCAC_STAT_ADDR;
  wire [6:0] sw_ctx = reg_addr[6:0];
  wire [10:0] wr_len = (reg_wdata[`TCAC_LEN_MSB:0] > `TCAC_LEN_MAX) ?
                       `TCAC_LEN_MAX : reg_wdata[`TCAC_LEN_MSB:0];

  tcac_dpram #(
    .DW (`TCAC_LUT_W),
    .AW (SLOTW)
  ) u_lut (
    .clk     (clk),
    .a_we    (lut_we),
    .a_addr  (s1_valid ? s1_idx : ts_index),
    .a_wdata (next_lut),
    .a_rdata (lut_q),
    .b_we    (reg_we & sw_lut),
    .b_addr  (reg_addr[SLOTW-1:0]),
    .b_wdata (reg_wdata[`TCAC_LUT_W-1:0]),
    .b_rdata (lut_b_q)
  );

  // assembly cache, drained by the memory manager
  tcac_dpram #(
    .DW (8),
    .AW (CAW)
  ) u_cache (
    .clk     (clk),
    .a_we    (store),
    .a_addr  (cache_addr),
    .a_wdata (s1_data),
    .a_rdata (),
    .b_we    (1'b0),
    .b_addr  (mem_rd_addr),
    .b_wdata (8'h00),
    .b_rdata (cache_b_q)
  );

  tcac_req u_req (
    .clk     (clk),
    .rst     (rst),
    .load    (pkt_close),
    .in_ctx  (e_cid),
    .in_base (pkt_base),
    .in_len  (c_cnt),
    .in_sw   (ctx_sw[e_cid]),
    .in_last (start_tdn),
    .gnt     (mem_gnt),
    .req     (mem_req),
    .ctx     (mem_ctx),
    .base    (mem_base),
    .len     (mem_len),
    .sw      (mem_switch),
    .last    (mem_last),
    .drop    (drop)
  );

  // per-slot decision on the entry read last cycle
  always @* begin
    // entry names one of 128 contexts
    e_cid  = lut_q[`TCAC_CID_MSB:0];
    e_on   = lut_q[`TCAC_ON_BIT];
    e_nx   = lut_q[`TCAC_NEXT_BIT];
    e_ld   = lut_q[`TCAC_LEAD_BIT];
    e_lnx  = lut_q[`TCAC_LNEXT_BIT];
    c_cnt  = ctx_cnt[e_cid];
    c_len  = (ctx_len[e_cid] == 11'h000) ? 11'h001 : ctx_len[e_cid];
    c_run  = ctx_run[e_cid];
    full   = c_cnt >= c_len;
    back   = (state != ST_IDLE) && (s1_idx == eng_slot);
    // update waits for first channel and a finished packet
    start_upd = s1_valid && (state == ST_IDLE) && ctx_upd[e_cid] &&
                !ctx_tdn[e_cid] && (c_run ? (e_ld && full) : e_lnx);
    // teardown starts at the context's first channel
    start_tdn = s1_valid && (state == ST_IDLE) && ctx_tdn[e_cid] &&
                (e_ld || e_lnx);
    // every member met during the cycle is switched over
    upd_mode = start_upd ||
               ((state == ST_UPD) && (eng_ctx == e_cid) && !back);
    clr_mode = start_tdn ||
               ((state == ST_CLR) && (eng_ctx == e_cid) && !back);
    // staged bits act from the update cycle onward
    eff_on = upd_mode ? e_nx : e_on;
    eff_ld = upd_mode ? e_lnx : e_ld;
    // packets close at the first channel: whole frames
    pkt_close = s1_valid && c_run &&
                ((eff_ld && full && !clr_mode) ||
                 (start_tdn && (c_cnt != 11'h000)));
    // only active members reach the payload
    store = s1_valid && !clr_mode && (c_run || start_upd) && eff_on;
    // bytes placed in scan order from the first channel
    wr_off = pkt_close ? 11'h000 : c_cnt;
    // packets alternate cache halves: a close keeps its first byte
    pkt_base   = ctx_ptr[e_cid] + {ctx_bank[e_cid], {(CAW-1){1'b0}}};
    wr_bank    = ctx_bank[e_cid] ^ pkt_close;
    cache_addr = ctx_ptr[e_cid] + {wr_bank, {(CAW-1){1'b0}}} +
                 {{(CAW-11){1'b0}}, wr_off};
    if (clr_mode) begin
      next_cnt = 11'h000;
    end else if (store) begin
      next_cnt = (wr_off == 11'h7FF) ? wr_off : wr_off + 11'h001;
    end else begin
      next_cnt = wr_off;
    end
    // copy staged bits; clear all flags
    if (clr_mode) begin
      next_lut = {4'h0, e_cid};
    end else begin
      next_lut = {e_lnx, e_lnx, e_nx, e_nx, e_cid};
    end
    lut_we = s1_valid && (upd_mode || clr_mode);
  end

  // slot pipeline, engine and context memory
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_valid <= 1'b0;
      s1_idx   <= {SLOTW{1'b0}};
      s1_data  <= 8'h00;
      state    <= ST_IDLE;
      eng_ctx  <= 7'h00;
      eng_slot <= {SLOTW{1'b0}};
      ovf      <= 1'b0;
      ctx_upd  <= {NCTX{1'b0}};
      ctx_tdn  <= {NCTX{1'b0}};
      ctx_sw   <= {NCTX{1'b0}};
      ctx_run  <= {NCTX{1'b0}};
      ctx_bank <= {NCTX{1'b0}};
      for (i = 0; i < NCTX; i = i + 1) begin
        ctx_len[i] <= `TCAC_LEN_RST;
        ctx_ptr[i] <= `TCAC_PTR_RST;
        ctx_cnt[i] <= 11'h000;
      end
    end else begin
      s1_valid <= ts_valid;
      s1_idx   <= ts_index;
      s1_data  <= ts_data;
      if (s1_valid) begin
        ctx_cnt[e_cid] <= next_cnt;
      end
      // a closed packet moves its context to the other cache half
      if (pkt_close) begin
        ctx_bank[e_cid] <= ~ctx_bank[e_cid];
      end
      // engine sequencing
      case (state)
        ST_IDLE: begin
          if (start_upd) begin
            state    <= ST_UPD;
            eng_ctx  <= e_cid;
            eng_slot <= s1_idx;
            ctx_run[e_cid] <= 1'b1;
            // first packet after update carries inverted switch
            ctx_sw[e_cid]  <= ~ctx_sw[e_cid];
          end else if (start_tdn) begin
            state    <= ST_CLR;
            eng_ctx  <= e_cid;
            eng_slot <= s1_idx;
          end
        end
        ST_UPD: begin
          // scan back at first channel ends the update
          if (s1_valid && back) begin
            state <= ST_IDLE;
            ctx_upd[eng_ctx] <= 1'b0;
          end
        end
        ST_CLR: begin
          if (s1_valid && back) begin
            state <= ST_IDLE;
            ctx_tdn[eng_ctx] <= 1'b0;
            ctx_run[eng_ctx] <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // sticky refused hand-over, write one to clear, set wins
      if (reg_we && sw_stat && reg_wdata[`TCAC_ST_OVF_BIT]) begin
        ovf <= 1'b0;
      end
      if (drop) begin
        ovf <= 1'b1;
      end
      // software programs per-context controls; its set wins
      if (reg_we && sw_ctrl) begin
        ctx_len[sw_ctx] <= wr_len;
        if (reg_wdata[`TCAC_UPD_BIT]) begin
          ctx_upd[sw_ctx] <= 1'b1;
        end
        if (reg_wdata[`TCAC_TDN_BIT]) begin
          ctx_tdn[sw_ctx] <= 1'b1;
        end
      end
      if (reg_we && sw_ptr) begin
        ctx_ptr[sw_ctx] <= reg_wdata[CAW-1:0];
      end
    end
  end

  // register read data and cache read data
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata   <= 32'h00000000;
      mem_rd_data <= 8'h00;
    end else begin
      mem_rd_data <= cache_b_q;
      reg_rdata   <= 32'h00000000;
      if (reg_re) begin
        if (sw_lut) begin
          reg_rdata <= {{(32-`TCAC_LUT_W){1'b0}}, lut_b_q};
        end else if (sw_ctrl) begin
          reg_rdata <= {12'h000, ctx_run[sw_ctx], ctx_sw[sw_ctx],
                        ctx_tdn[sw_ctx], ctx_upd[sw_ctx],
                        5'h00, ctx_len[sw_ctx]};
        end else if (sw_ptr) begin
          reg_rdata <= {{(32-CAW){1'b0}}, ctx_ptr[sw_ctx]};
        end else if (sw_stat) begin
          reg_rdata <= {28'h0000000, mem_req, state[2], state[1], ovf};
        end
      end
    end
  end

endmodule

//--- verif/tcac_checker.sv
// assertion checker bound to the context control block
`timescale 1ns/10ps
module tcac_checker #(
  parameter NCTX = 128,
  parameter CAW  = 12
) (
  input wire           clk,        // system clock
  input wire           rst,        // async reset
  input wire           ts_valid,   // slot strobe
  input wire [10:0]    reg_addr,   // register address
  input wire           reg_re,     // read strobe
  input wire [31:0]    reg_rdata,  // read data
  input wire           mem_req,    // packet waiting
  input wire [6:0]     mem_ctx,    // packet context
  input wire [CAW-1:0] mem_base,   // packet base
  input wire [10:0]    mem_len,    // packet length
  input wire           mem_switch, // switch bit
  input wire           mem_last,   // final packet
  input wire           mem_gnt     // grant pulse
);
  // descriptor fields seen as one word
  wire [CAW+19:0] desc = {mem_ctx, mem_base, mem_len, mem_switch, mem_last};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  chk_unmapped_zero: assert property (reg_re && reg_addr > 11'h500 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_len_clamp: assert property (reg_re && reg_addr[10:7] == 4'h8 |=> reg_rdata[10:0] <= 11'h5DC)
    else $error("stored length above limit");
  chk_req_hold: assert property (mem_req && !mem_gnt |=> mem_req)
    else $error("request dropped before grant");
  chk_desc_stable: assert property (mem_req && !mem_gnt |=> $stable(desc))
    else $error("descriptor changed while waiting");
  chk_req_cause: assert property ($rose(mem_req) |-> $past(ts_valid, 2))
    else $error("request without a slot two cycles before");
  chk_len_range: assert property ($rose(mem_req) |-> mem_len >= 11'h001 && mem_len <= 11'h5DC)
    else $error("packet length out of range");
  // no packet can load at a grant edge without a slot the cycle before
  chk_gnt_release: assert property
    (mem_req && mem_gnt && !$past(ts_valid) |=> !mem_req)
    else $error("request still high after grant");
endmodule

bind tcac_ctx_ctrl tcac_checker #(.NCTX(NCTX), .CAW(CAW)) u_chk (
  .clk(clk), .rst(rst), .ts_valid(ts_valid), .reg_addr(reg_addr),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .mem_req(mem_req),
  .mem_ctx(mem_ctx), .mem_base(mem_base), .mem_len(mem_len),
  .mem_switch(mem_switch), .mem_last(mem_last), .mem_gnt(mem_gnt)
);

//--- verif/tcac_far_model.sv
// timeslot source and memory manager model at the far side
`timescale 1ns/10ps
module tcac_far_model (
  input  wire        clk,         // system clock
  output reg         ts_valid,    // slot strobe
  output reg  [9:0]  ts_index,    // slot position
  output reg  [7:0]  ts_data,     // slot byte
  input  wire        mem_req,     // packet waiting
  input  wire [6:0]  mem_ctx,     // packet context
  input  wire [11:0] mem_base,    // packet base
  input  wire [10:0] mem_len,     // packet length
  input  wire        mem_switch,  // switch bit
  input  wire        mem_last,    // final packet
  output reg         mem_gnt,     // grant pulse
  output reg  [11:0] mem_rd_addr, // cache read address
  input  wire [7:0]  mem_rd_data  // cache byte
);
  logic [31:0] rx_desc[$]; // descriptors taken
  logic [7:0]  rx_byte[$]; // bytes read back
  integer      i;
  integer      n;
  // idle values at time zero
  initial begin
    ts_valid = 1'b0;
    ts_index = 10'h000;
    ts_data = 8'h00;
    mem_gnt = 1'b0;
    mem_rd_addr = 12'h000;
  end
  // one slot byte, spaced two cycles, data inverted when idle
  task automatic send_slot(input [9:0] idx, input [7:0] d);
    @(posedge clk);
    ts_valid <= 1'b1;
    ts_index <= idx;
    ts_data <= d;
    @(posedge clk);
    ts_valid <= 1'b0;
    ts_data <= ~d;
  endtask
  // read the packet out of the cache, then grant after a random stall
  initial begin
    forever begin
      @(negedge clk);
      if (mem_req === 1'b1) begin
        rx_desc.push_back({mem_ctx, mem_base, mem_len, mem_switch, mem_last});
        n = mem_len;
        for (i = 0; i <= n; i++) begin
          @(posedge clk);
          mem_rd_addr <= mem_base + i[11:0];
          @(negedge clk);
          if (i > 0) rx_byte.push_back(mem_rd_data);
        end
        repeat ($urandom % 4) @(posedge clk);
        @(posedge clk);
        mem_gnt <= 1'b1;
        @(posedge clk);
        mem_gnt <= 1'b0;
      end
    end
  end
endmodule

//--- verif/tdm_context_assembly_control_tb_top.sv
// self-checking bench for the context control block
`timescale 1ns/10ps
`include "tcac_defines.vh"
module tdm_context_assembly_control_tb_top;
  logic        clk;
  logic        rst;
  logic [10:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_we;
  logic        reg_re;
  wire  [31:0] reg_rdata;
  wire         ts_valid;
  wire  [9:0]  ts_index;
  wire  [7:0]  ts_data;
  wire         mem_req;
  wire  [6:0]  mem_ctx;
  wire  [11:0] mem_base;
  wire  [10:0] mem_len;
  wire         mem_switch;
  wire         mem_last;
  wire         mem_gnt;
  wire  [11:0] mem_rd_addr;
  wire  [7:0]  mem_rd_data;
  integer      n_mismatch;
  integer      comparisons;
  integer      on;      // model: context running
  integer      upd;     // model: update pending
  integer      tdn;     // model: teardown pending
  integer      sw;      // model: switch bit
  integer      bk;      // model: cache half of the next packet
  integer      mb[16];  // model: member_on per slot
  integer      nb[16];  // model: member_next per slot
  logic [7:0]  q[$];    // model: bytes of the open packet
  logic [31:0] ed[$];   // expected descriptors
  logic [7:0]  eb[$];   // expected bytes
  tcac_ctx_ctrl u_dut (
    .clk(clk), .rst(rst), .ts_valid(ts_valid), .ts_index(ts_index),
    .ts_data(ts_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_ctx(mem_ctx), .mem_base(mem_base),
    .mem_len(mem_len), .mem_switch(mem_switch), .mem_last(mem_last),
    .mem_gnt(mem_gnt), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data)
  );
  tcac_far_model u_far (
    .clk(clk), .ts_valid(ts_valid), .ts_index(ts_index),
    .ts_data(ts_data), .mem_req(mem_req), .mem_ctx(mem_ctx),
    .mem_base(mem_base), .mem_len(mem_len), .mem_switch(mem_switch),
    .mem_last(mem_last), .mem_gnt(mem_gnt), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data)
  );
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // count and report one comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // register write, one strobe cycle
  task automatic wr(input [10:0] a, input [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  // register read, data taken in the cycle after the strobe
  task automatic rd(input [10:0] a, input [31:0] m, input [31:0] e);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    chk(reg_rdata & m, e);
  endtask
  // compare packets taken by the manager with the model
  task automatic pkt;
    chk(u_far.rx_desc.size(), ed.size());
    chk(u_far.rx_byte.size(), eb.size());
    while (ed.size() > 0 && u_far.rx_desc.size() > 0)
      chk(u_far.rx_desc.pop_front(), ed.pop_front());
    while (eb.size() > 0 && u_far.rx_byte.size() > 0)
      chk({24'h0, u_far.rx_byte.pop_front()}, {24'h0, eb.pop_front()});
  endtask
  // close the open model packet
  task automatic emit(input integer l);
    logic [10:0] n;
    n = q.size();
    // packets of the context alternate between its two cache halves
    ed.push_back({7'h05, bk ? 12'h900 : 12'h100, n, sw[0], l[0]});
    bk = 1 - bk;
    eb = {eb, q};
    q = {};
  endtask
  // one frame of 16 slots through the model and the design
  task automatic frame;
    integer     s;
    logic [7:0] d;
    for (s = 0; s < 16; s++) begin
      d = $urandom;
      if (s == 3 && tdn && on) begin
        if (q.size() > 0) emit(1);
        on = 0;
        tdn = 0;
      end else if (s == 3 && (!on && upd || on && q.size() >= 4)) begin
        if (on) emit(0);
        if (upd) begin
          sw = 1 - sw;
          on = 1;
          upd = 0;
          mb = nb;
        end
      end
      if (on && mb[s]) q.push_back(d);
      u_far.send_slot(s[9:0], d);
    end
  endtask
  // watchdog
  initial begin
    #800000;
    n_mismatch++;
    stop_test();
  end
  // main sequence
  initial begin
    integer s;
    rst = 1'b1;
    reg_addr = 11'h000;
    reg_wdata = 32'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    on = 0;
    upd = 0;
    tdn = 0;
    sw = 0;
    bk = 0;
    for (s = 0; s < 16; s++) begin
      mb[s] = 0;
      nb[s] = s == 3 || s == 7;
    end
    void'($urandom(2));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`TCAC_CTRL_BASE + 11'h005, 32'hFFFFFFFF, 32'h20);
    rd(`TCAC_PTR_BASE + 11'h005, 32'hFFFFFFFF, 32'h0);
    rd(11'h600, 32'hFFFFFFFF, 32'h0);
    wr(`TCAC_CTRL_BASE + 11'h005, 32'h7D0);
    rd(`TCAC_CTRL_BASE + 11'h005, 32'h7FF, 32'h5DC);
    wr(`TCAC_PTR_BASE + 11'h005, 32'h100);
    rd(`TCAC_PTR_BASE + 11'h005, 32'hFFF, 32'h100);
    for (s = 0; s < 16; s++)
      wr(s[10:0], s == 3 ? 32'h505 : s == 7 ? 32'h105 : 32'h0);
    $display("test registers done");
    wr(`TCAC_CTRL_BASE + 11'h005, 32'h10004);
    upd = 1;
    frame();
    rd(11'h003, 32'h780, 32'h780);
    frame();
    rd(`TCAC_CTRL_BASE + 11'h005, 32'h90000, 32'h80000);
    frame();
    pkt();
    $display("test setup done");
    wr(11'h009, 32'h105);
    nb[9] = 1;
    wr(11'h007, 32'h085);
    nb[7] = 0;
    wr(`TCAC_CTRL_BASE + 11'h005, 32'h10004);
    upd = 1;
    frame();
    rd(`TCAC_CTRL_BASE + 11'h005, 32'h10000, 32'h10000);
    frame();
    rd(`TCAC_STAT_ADDR, 32'hF, 32'h2);
    frame();
    rd(`TCAC_CTRL_BASE + 11'h005, 32'h10000, 32'h0);
    rd(11'h009, 32'h7FF, 32'h185);
    rd(11'h007, 32'h7FF, 32'h005);
    frame();
    pkt();
    $display("test modify done");
    wr(`TCAC_CTRL_BASE + 11'h005, 32'h20004);
    tdn = 1;
    frame();
    rd(`TCAC_STAT_ADDR, 32'hF, 32'h4);
    frame();
    pkt();
    rd(11'h003, 32'h780, 32'h0);
    rd(`TCAC_CTRL_BASE + 11'h005, 32'hA0000, 32'h0);
    frame();
    pkt();
    $display("test teardown done");
    stop_test();
  end
endmodule
